// ---- fcsl_array.sv ----
// fcsl_array: byte array and per-block lock bits of the flash
// assumes the sequencer never asserts two update strobes at once
`timescale 1ns/1ps

module fcsl_array
  import fcsl_pkg::*;
#(
  parameter int unsigned BW = BLK_W,
  parameter int unsigned NBW = 3
)
(
  // clock
  input wire logic clk_i,
  // update strobes
  input wire logic prog_i,
  input wire logic erase_i,
  input wire logic lock_clr_i,
  // operation target
  input wire logic [BW+NBW-1:0] op_addr_i,
  input wire logic [7:0] op_data_i,
  // bus read port
  input wire logic [BW+NBW-1:0] rd_addr_i,
  output logic [7:0] rd_data_o,
  // operation views
  output logic [7:0] op_rd_o,
  output logic lock_o,
  output logic blank_o
);

  localparam int unsigned NBYTE = 2 ** (BW + NBW);
  localparam int unsigned NBLK = 2 ** NBW;

  logic [7:0] mem [0:NBYTE-1];
  logic lock_bits [0:NBLK-1];
  logic [NBW-1:0] blk;

  // nonvolatile contents start erased and unlocked
  initial
  begin
    for (int i = 0; i < NBYTE; i++)
    begin
      mem[i] = ERASED_BYTE;
    end
    for (int j = 0; j < NBLK; j++)
    begin
      lock_bits[j] = 1'b1;
    end
  end

  assign blk = op_addr_i[BW+NBW-1:BW];
  assign rd_data_o = mem[rd_addr_i];
  assign op_rd_o = mem[op_addr_i];
  assign lock_o = lock_bits[blk];

  always_comb
  begin
    blank_o = 1'b1;
    for (int k = 0; k < 2 ** BW; k++)
    begin
      if (mem[{blk, BW'(k)}] != ERASED_BYTE)
      begin
        blank_o = 1'b0;
      end
    end
  end

  // programming only clears bits
  always_ff @(posedge clk_i)
  begin
    if (prog_i)
    begin
      mem[op_addr_i] <= mem[op_addr_i] & op_data_i;
    end
    else if (erase_i)
    begin
      for (int k = 0; k < 2 ** BW; k++)
      begin
        mem[{blk, BW'(k)}] <= ERASED_BYTE;
      end
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (lock_clr_i)
    begin
      lock_bits[blk] <= 1'b0;
    end
    else if (erase_i)
    begin
      lock_bits[blk] <= 1'b1;
    end
  end

endmodule : fcsl_array

// ---- fcsl_cpu_bfm.sv ----
// fcsl_cpu_bfm: cpu side issuing byte bus cycles
// assumes calls start one ns after a rising edge
`timescale 1ns/1ps

module fcsl_cpu_bfm
  import fcsl_pkg::*;
(
  // clock
  input wire logic clk_i,
  // byte bus
  output logic [ADDR_W-1:0] addr_o,
  output logic [7:0] wdata_o,
  output logic wr_o,
  output logic rd_o,
  input wire logic [7:0] rdata_i
);
  initial
  begin
    addr_o = 12'h000;
    wdata_o = 8'h00;
    wr_o = 1'b0;
    rd_o = 1'b0;
  end

  task automatic put(input logic [11:0] a, input logic [7:0] d, input logic w, input logic r);
    addr_o <= a;
    wdata_o <= d;
    wr_o <= w;
    rd_o <= r;
    @(posedge clk_i);
    #1;
  endtask : put

  // unused lines flip so stale values never look valid
  task automatic idle();
    put(~addr_o, ~wdata_o, 1'b0, 1'b0);
  endtask : idle

  task automatic wr_b(input logic [11:0] a, input logic [7:0] d);
    put(a, d, 1'b1, 1'b0);
  endtask : wr_b

  task automatic rd_b(input logic [11:0] a, output logic [7:0] d);
    put(a, ~wdata_o, 1'b0, 1'b1);
    d = rdata_i;
  endtask : rd_b

  task automatic prog(input logic [11:0] a, input logic [7:0] d);
    wr_b(a, CMD_PROGRAM);
    wr_b(a, d);
  endtask : prog

  task automatic cmd2(input logic [7:0] c, input logic [11:0] a);
    wr_b(a, c);
    wr_b(a, CMD_CONFIRM);
  endtask : cmd2
endmodule : fcsl_cpu_bfm

// ---- fcsl_pkg.sv ----
// fcsl_pkg: constants for the flash command sequencer with block locks
// assumes a 100 MHz cpu clock; flash and control share one byte address space
package fcsl_pkg;

  // clock and operation times
  localparam int unsigned CLK_PERIOD_NS = 10;
  localparam int unsigned PROG_TIME_NS = 50_000;
  localparam int unsigned ERASE_TIME_NS = 3_000_000;
  localparam int unsigned AUX_TIME_NS = 100;

  // least time to whole cycles, never below one
  function automatic int unsigned fcsl_cyc(input int unsigned t_ns);
    int unsigned c;
    c = (t_ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    return (c == 0) ? 1 : c;
  endfunction : fcsl_cyc

  localparam int unsigned PROG_CYCLES = fcsl_cyc(PROG_TIME_NS);
  localparam int unsigned ERASE_CYCLES = fcsl_cyc(ERASE_TIME_NS);
  localparam int unsigned AUX_CYCLES = fcsl_cyc(AUX_TIME_NS);

  // geometry
  localparam int unsigned ADDR_W = 12;
  localparam int unsigned BLK_W = 8;

  // command codes
  localparam logic [7:0] CMD_READ_ARRAY = 8'hff;
  localparam logic [7:0] CMD_CLR_STATUS = 8'h50;
  localparam logic [7:0] CMD_PROGRAM = 8'h40;
  localparam logic [7:0] CMD_ERASE = 8'h20;
  localparam logic [7:0] CMD_LOCK_PROG = 8'h77;
  localparam logic [7:0] CMD_LOCK_READ = 8'h71;
  localparam logic [7:0] CMD_BLANK = 8'h25;
  localparam logic [7:0] CMD_CONFIRM = 8'hd0;

  // control register offsets inside the register half
  localparam int unsigned REG_CTRL0 = 0;
  localparam int unsigned REG_CTRL1 = 1;
  localparam int unsigned REG_CTRL2 = 2;
  localparam int unsigned REG_STATUS = 3;

  // ctrl0 fields
  localparam int unsigned C0_REWRITE_EN = 0;
  localparam int unsigned C0_FLASH_STOP = 1;
  localparam int unsigned C0_CMD_RESET = 2;
  localparam int unsigned C0_RDY_IE = 3;
  // ctrl1 fields
  localparam int unsigned C1_LOCK_OVR = 0;
  localparam int unsigned C1_DF_DIS = 4;
  // ctrl2 fields
  localparam int unsigned C2_SUS_EN = 0;
  localparam int unsigned C2_SUS_REQ = 1;
  // status fields
  localparam int unsigned ST_READY = 7;
  localparam int unsigned ST_SUSP = 6;
  localparam int unsigned ST_ERASE_ERR = 5;
  localparam int unsigned ST_PROG_ERR = 4;
  localparam int unsigned ST_LOCK_DATA = 1;
  localparam int unsigned ST_READ_ARRAY = 0;

  // reset, erased and no-data byte values
  localparam logic [7:0] RST_CTRL = 8'h00;
  localparam logic [7:0] ERASED_BYTE = 8'hff;
  localparam logic [7:0] NO_DATA = 8'h00;

  typedef enum {FCSL_IDLE, FCSL_CMD2, FCSL_BUSY, FCSL_SUSP} fcsl_state_t;
  typedef enum {OP_PROG, OP_ERASE, OP_LOCK, OP_LREAD, OP_BLANK} fcsl_op_t;

endpackage : fcsl_pkg

// ---- fcsl_seq.sv ----
// fcsl_seq: byte command sequencer for on-chip flash rewrite
// assumes cpu byte bus: one-cycle strobes, read data in the next cycle
//
// Implementation choices: the register addresses and the address-and-strobe port.
`timescale 1ns/1ps

module fcsl_seq
  import fcsl_pkg::*;
#(
  parameter int unsigned AW = ADDR_W,
  parameter int unsigned BW = BLK_W,
  parameter int unsigned PROG_CYC = PROG_CYCLES,
  parameter int unsigned ERASE_CYC = ERASE_CYCLES,
  parameter int unsigned AUX_CYC = AUX_CYCLES
)
(
  // clock and reset
  input wire logic clk_i,
  input wire logic nrst_i,
  // cpu byte bus
  input wire logic [AW-1:0] addr_i,
  input wire logic [7:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [7:0] rdata_o,
  // flash ready interrupt
  output logic ready_irq_o
);

  localparam int unsigned FW = AW - 1;
  localparam int unsigned NBW = FW - BW;

  ////////////////////////////////////////////////////////////////////////
  // decode

  function automatic logic reg_hit(input logic [AW-1:0] a, input int unsigned off);
    return a[AW-1] && (a[FW-1:0] == FW'(off));
  endfunction : reg_hit

  function automatic logic is_df(input logic [FW-1:0] a);
    return a[FW-1];
  endfunction : is_df

  fcsl_state_t state_r;
  fcsl_op_t op_r;
  logic [7:0] cmd1_r;
  logic [FW-1:0] op_addr_r;
  logic [7:0] op_data_r;
  logic [31:0] cnt_r;
  logic cpu_rewrite_enable_r;
  logic flash_stop_r;
  logic ready_interrupt_enable_r;
  logic lock_override_r;
  logic [3:0] dflash_rewrite_disable_r;
  logic erase_suspend_enable_r;
  logic erase_suspend_request_r;
  logic program_error_flag_r;
  logic erase_error_flag_r;
  logic lock_data_r;
  logic read_array_r;
  logic ready_flag;
  logic [7:0] status;
  logic [FW-1:0] fa;
  logic flash_wr;
  logic c0_wr;
  logic command_reset;
  logic seq_err;
  logic start;
  logic done;
  logic sus_enter;
  logic [FW-1:0] tgt;
  logic [NBW-1:0] tgt_blk;
  logic locked;
  logic df_refused;
  logic [7:0] arr_rd;
  logic [7:0] arr_op_rd;
  logic arr_lock;
  logic arr_blank;
  fcsl_op_t new_op;

  assign fa = addr_i[FW-1:0];
  assign flash_wr = wr_i && !addr_i[AW-1] && cpu_rewrite_enable_r && !flash_stop_r;
  assign c0_wr = wr_i && reg_hit(addr_i, REG_CTRL0);
  assign command_reset = c0_wr && wdata_i[C0_CMD_RESET];
  assign ready_flag = (state_r != FCSL_BUSY);
  assign tgt = (state_r == FCSL_CMD2) ? fa : op_addr_r;
  assign tgt_blk = tgt[FW-1:BW];

  ////////////////////////////////////////////////////////////////////////
  // command decode

  always_comb
  begin
    seq_err = 1'b0;
    start = 1'b0;
    new_op = OP_PROG;
    if (flash_wr && (state_r == FCSL_IDLE || state_r == FCSL_SUSP))
    begin
      case (wdata_i)
        CMD_READ_ARRAY, CMD_CLR_STATUS: seq_err = 1'b0;
        CMD_PROGRAM, CMD_ERASE, CMD_LOCK_PROG, CMD_LOCK_READ, CMD_BLANK:
          seq_err = (state_r == FCSL_SUSP);
        default: seq_err = 1'b1;
      endcase
    end
    else if (flash_wr && state_r == FCSL_CMD2 && wdata_i != CMD_READ_ARRAY)
    begin
      start = (cmd1_r == CMD_PROGRAM) || (wdata_i == CMD_CONFIRM);
      seq_err = !start;
      case (cmd1_r)
        CMD_PROGRAM: new_op = OP_PROG;
        CMD_ERASE: new_op = OP_ERASE;
        CMD_LOCK_PROG: new_op = OP_LOCK;
        CMD_LOCK_READ: new_op = OP_LREAD;
        default: new_op = OP_BLANK;
      endcase
    end
  end

  // lock check sees override as unlocked; stored bit untouched
  assign locked = !arr_lock && !lock_override_r;
  assign df_refused = is_df(tgt) && dflash_rewrite_disable_r[tgt_blk[1:0]];
  assign done = (state_r == FCSL_BUSY) && (cnt_r == 32'h0000_0001);
  assign sus_enter = (state_r == FCSL_BUSY) && (op_r == OP_ERASE)
    && erase_suspend_enable_r && erase_suspend_request_r && !done;

  ////////////////////////////////////////////////////////////////////////
  // sequencer state

  always_ff @(posedge clk_i)
  begin
    if (!nrst_i)
    begin
      state_r <= FCSL_IDLE;
      op_r <= OP_PROG;
      cmd1_r <= 8'h00;
      op_addr_r <= '0;
      op_data_r <= 8'h00;
      cnt_r <= 32'h0000_0000;
    end
    else if (command_reset)
    begin
      state_r <= FCSL_IDLE;
    end
    else
    begin
      case (state_r)
        FCSL_IDLE, FCSL_SUSP:
        begin
          if (state_r == FCSL_SUSP && !erase_suspend_request_r)
          begin
            state_r <= FCSL_BUSY;
          end
          else if (flash_wr && !seq_err && wdata_i != CMD_READ_ARRAY
            && wdata_i != CMD_CLR_STATUS)
          begin
            state_r <= FCSL_CMD2;
            cmd1_r <= wdata_i;
          end
        end
        FCSL_CMD2:
        begin
          if (flash_wr)
          begin
            state_r <= FCSL_IDLE;
            if (start)
            begin
              op_r <= new_op;
              op_addr_r <= fa;
              op_data_r <= wdata_i;
              if (new_op == OP_PROG && !locked)
              begin
                state_r <= FCSL_BUSY;
                cnt_r <= PROG_CYC;
              end
              else if (new_op == OP_ERASE && !locked && !df_refused)
              begin
                state_r <= FCSL_BUSY;
                cnt_r <= ERASE_CYC;
              end
              else if (new_op != OP_PROG && new_op != OP_ERASE)
              begin
                state_r <= FCSL_BUSY;
                cnt_r <= AUX_CYC;
              end
            end
          end
        end
        FCSL_BUSY:
        begin
          if (sus_enter)
          begin
            state_r <= FCSL_SUSP;
          end
          else if (done)
          begin
            state_r <= FCSL_IDLE;
          end
          else
          begin
            cnt_r <= cnt_r - 32'h0000_0001;
          end
        end
        default: state_r <= FCSL_IDLE;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // status flags

  always_ff @(posedge clk_i)
  begin
    if (!nrst_i)
    begin
      program_error_flag_r <= 1'b0;
      erase_error_flag_r <= 1'b0;
      lock_data_r <= 1'b0;
      read_array_r <= 1'b1;
    end
    else
    begin
      if (flash_wr && state_r != FCSL_BUSY && wdata_i == CMD_CLR_STATUS
        && state_r != FCSL_CMD2)
      begin
        program_error_flag_r <= 1'b0;
        erase_error_flag_r <= 1'b0;
      end
      if (flash_wr && wdata_i == CMD_READ_ARRAY && state_r != FCSL_BUSY)
      begin
        read_array_r <= 1'b1;
      end
      else if (flash_wr && state_r == FCSL_CMD2)
      begin
        read_array_r <= 1'b0;
      end
      if (seq_err)
      begin
        program_error_flag_r <= 1'b1;
        erase_error_flag_r <= 1'b1;
      end
      if (start && locked && new_op == OP_PROG)
      begin
        program_error_flag_r <= 1'b1;
      end
      if (start && locked && new_op == OP_ERASE && !df_refused)
      begin
        erase_error_flag_r <= 1'b1;
      end
      if (done && op_r == OP_PROG)
      begin
        program_error_flag_r <= (arr_op_rd & op_data_r) != op_data_r;
      end
      if (done && op_r == OP_BLANK)
      begin
        erase_error_flag_r <= !arr_blank;
      end
      if (done && op_r == OP_LREAD)
      begin
        lock_data_r <= arr_lock;
      end
      if (done || sus_enter || command_reset)
      begin
        read_array_r <= 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // control registers

  always_ff @(posedge clk_i)
  begin
    if (!nrst_i)
    begin
      cpu_rewrite_enable_r <= RST_CTRL[C0_REWRITE_EN];
      flash_stop_r <= RST_CTRL[C0_FLASH_STOP];
      ready_interrupt_enable_r <= RST_CTRL[C0_RDY_IE];
      dflash_rewrite_disable_r <= RST_CTRL[C1_DF_DIS+:4];
      erase_suspend_enable_r <= RST_CTRL[C2_SUS_EN];
      erase_suspend_request_r <= RST_CTRL[C2_SUS_REQ];
    end
    else
    begin
      if (c0_wr)
      begin
        cpu_rewrite_enable_r <= wdata_i[C0_REWRITE_EN];
        flash_stop_r <= wdata_i[C0_FLASH_STOP];
        ready_interrupt_enable_r <= wdata_i[C0_RDY_IE];
      end
      if (wr_i && reg_hit(addr_i, REG_CTRL1))
      begin
        dflash_rewrite_disable_r <= wdata_i[C1_DF_DIS+:4];
      end
      if (wr_i && reg_hit(addr_i, REG_CTRL2))
      begin
        erase_suspend_enable_r <= wdata_i[C2_SUS_EN];
        erase_suspend_request_r <= wdata_i[C2_SUS_REQ];
      end
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (!nrst_i)
    begin
      lock_override_r <= RST_CTRL[C1_LOCK_OVR];
    end
    else if (done || sus_enter || seq_err || command_reset
      || (c0_wr && (!wdata_i[C0_REWRITE_EN] || wdata_i[C0_FLASH_STOP])))
    begin
      lock_override_r <= 1'b0;
    end
    else if (wr_i && reg_hit(addr_i, REG_CTRL1))
    begin
      lock_override_r <= wdata_i[C1_LOCK_OVR];
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // read path and interrupt

  always_comb
  begin
    status = 8'h00;
    status[ST_READY] = ready_flag;
    status[ST_SUSP] = (state_r == FCSL_SUSP);
    status[ST_ERASE_ERR] = erase_error_flag_r;
    status[ST_PROG_ERR] = program_error_flag_r;
    status[ST_LOCK_DATA] = lock_data_r;
    status[ST_READ_ARRAY] = read_array_r;
  end

  always_ff @(posedge clk_i)
  begin
    if (!nrst_i)
    begin
      rdata_o <= 8'h00;
    end
    else if (rd_i && addr_i[AW-1])
    begin
      if (reg_hit(addr_i, REG_CTRL0))
        rdata_o <= {4'h0, ready_interrupt_enable_r, 1'b0, flash_stop_r,
          cpu_rewrite_enable_r};
      else if (reg_hit(addr_i, REG_CTRL1))
        rdata_o <= {dflash_rewrite_disable_r, 3'b000, lock_override_r};
      else if (reg_hit(addr_i, REG_CTRL2))
        rdata_o <= {6'b00_0000, erase_suspend_request_r, erase_suspend_enable_r};
      else if (reg_hit(addr_i, REG_STATUS))
        rdata_o <= status;
      else
        rdata_o <= 8'h00;
    end
    else if (rd_i)
    begin
      if (flash_stop_r)
        rdata_o <= NO_DATA;
      else if (state_r == FCSL_BUSY)
        rdata_o <= (is_df(op_addr_r) && !is_df(fa)) ? arr_rd : NO_DATA;
      else if (state_r == FCSL_SUSP)
        rdata_o <= (fa[FW-1:BW] == op_addr_r[FW-1:BW]) ? NO_DATA : arr_rd;
      else
        rdata_o <= read_array_r ? arr_rd : status;
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (!nrst_i)
    begin
      ready_irq_o <= 1'b0;
    end
    else
    begin
      ready_irq_o <= ready_interrupt_enable_r
        && ((done && (op_r == OP_PROG || op_r == OP_ERASE))
        || sus_enter);
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // array

  fcsl_array #(
    .BW(BW),
    .NBW(NBW)
  ) u_array (
    .clk_i(clk_i),
    .prog_i(done && op_r == OP_PROG),
    .erase_i(done && op_r == OP_ERASE),
    .lock_clr_i(done && op_r == OP_LOCK),
    .op_addr_i(tgt),
    .op_data_i(op_data_r),
    .rd_addr_i(fa),
    .rd_data_o(arr_rd),
    .op_rd_o(arr_op_rd),
    .lock_o(arr_lock),
    .blank_o(arr_blank)
  );

endmodule : fcsl_seq

// ---- fcsl_seq_sva.sv ----
// fcsl_seq_sva: port checks for the flash command sequencer
// assumes flash writes never arrive while an operation runs
`timescale 1ns/1ps

module fcsl_seq_sva
  import fcsl_pkg::*;
#(
  parameter int unsigned PROG_CYC = PROG_CYCLES
)
(
  // clock and reset
  input wire logic clk_i,
  input wire logic nrst_i,
  // cpu byte bus
  input wire logic [ADDR_W-1:0] addr_i,
  input wire logic [7:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  input wire logic [7:0] rdata_o,
  // interrupt
  input wire logic ready_irq_o
);
  localparam int P_IRQ = PROG_CYC + 1;
  logic en_r, ie_r, pend_r, pg_r;
  logic [31:0] irq_cnt_r;
  logic fw, c0w, go, st_rd, c1_rd, err_wr;

  function automatic logic is_first(input logic [7:0] d);
    return d inside {CMD_PROGRAM, CMD_ERASE, CMD_LOCK_PROG, CMD_LOCK_READ, CMD_BLANK};
  endfunction : is_first

  function automatic logic is_bad(input logic [7:0] d);
    return !is_first(d) && !(d inside {CMD_READ_ARRAY, CMD_CLR_STATUS, CMD_CONFIRM});
  endfunction : is_bad

  assign fw = wr_i && !addr_i[11] && en_r;
  assign c0w = wr_i && addr_i == 12'h800;
  assign go = fw && pend_r && pg_r && wdata_i != CMD_READ_ARRAY;
  assign st_rd = rd_i && addr_i == 12'h803;
  assign c1_rd = rd_i && addr_i == 12'h801;
  assign err_wr = fw && !pend_r && is_bad(wdata_i);

  ////////////////////////////////////////////////////////////////
  // shadow of enables and command phase
  always_ff @(posedge clk_i)
  begin
    if (!nrst_i)
    begin
      en_r <= 1'b0;
      ie_r <= 1'b0;
    end
    else if (c0w)
    begin
      en_r <= wdata_i[C0_REWRITE_EN] && !wdata_i[C0_FLASH_STOP];
      ie_r <= wdata_i[C0_RDY_IE];
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (!nrst_i || c0w)
    begin
      pend_r <= 1'b0;
      pg_r <= 1'b0;
    end
    else if (fw)
    begin
      pend_r <= !pend_r && is_first(wdata_i);
      pg_r <= !pend_r && wdata_i == CMD_PROGRAM;
    end
  end

  // cycles left until the program end interrupt is due
  always_ff @(posedge clk_i)
  begin
    if (!nrst_i)
    begin
      irq_cnt_r <= 32'h0000_0000;
    end
    else if (go && ie_r)
    begin
      irq_cnt_r <= 32'(P_IRQ);
    end
    else if (irq_cnt_r != 32'h0000_0000)
    begin
      irq_cnt_r <= irq_cnt_r - 32'h0000_0001;
    end
  end

  ////////////////////////////////////////////////////////////////
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!nrst_i);

  a_irq_one_pulse: assert property (ready_irq_o |=> !ready_irq_o)
    else $error("ready interrupt longer than one cycle");
  a_irq_needs_enable: assert property (ready_irq_o |-> $past(ie_r))
    else $error("ready interrupt while disabled");
  a_irq_prog_time: assert property (irq_cnt_r == 32'h0000_0001 |-> ready_irq_o)
    else $error("program end interrupt late or missing");
  a_busy_not_ready: assert property (go ##1 st_rd |=> !rdata_o[ST_READY])
    else $error("ready high during program");
  a_clear_flags: assert property (fw && !pend_r && wdata_i == CMD_CLR_STATUS ##1 st_rd
    |=> rdata_o[5:4] == 2'b00)
    else $error("error flags not cleared");
  a_seq_err_flags: assert property (err_wr ##1 st_rd |=> rdata_o[5:4] == 2'b11)
    else $error("sequence error flags wrong");
  a_seq_err_ovr: assert property (err_wr ##1 c1_rd |=> !rdata_o[C1_LOCK_OVR])
    else $error("override kept after sequence error");
  a_read_array_mode: assert property (fw && wdata_i == CMD_READ_ARRAY ##1 st_rd
    |=> rdata_o[ST_READ_ARRAY])
    else $error("read array mode not entered");
  a_rdata_stands: assert property (!rd_i |=> $stable(rdata_o))
    else $error("read data changed without read");
endmodule : fcsl_seq_sva

bind fcsl_seq fcsl_seq_sva #(.PROG_CYC(PROG_CYC)) u_sva (
  .clk_i(clk_i),
  .nrst_i(nrst_i),
  .addr_i(addr_i),
  .wdata_i(wdata_i),
  .wr_i(wr_i),
  .rd_i(rd_i),
  .rdata_o(rdata_o),
  .ready_irq_o(ready_irq_o)
);

// ---- tb.sv ----
// tb: self-checking bench for the flash command sequencer
// assumes short operation counts set through parameters
`timescale 1ns/1ps

module tb
  import fcsl_pkg::*;
;
  localparam int PC = 20;
  logic clk_i = 1'b0;
  logic nrst_i;
  logic [11:0] addr, pa [4];
  logic [7:0] wdata, rdata, d, c, pd [4];
  logic wr, rd, irq;
  logic [31:0] seed;
  int n_fail, check_count, n;

  always #5 clk_i = ~clk_i;

  fcsl_cpu_bfm cpu (.clk_i(clk_i), .addr_o(addr), .wdata_o(wdata), .wr_o(wr), .rd_o(rd),
    .rdata_i(rdata));
  fcsl_seq #(.PROG_CYC(PC), .ERASE_CYC(40), .AUX_CYC(4)) dut (.clk_i(clk_i),
    .nrst_i(nrst_i), .addr_i(addr), .wdata_i(wdata), .wr_i(wr), .rd_i(rd),
    .rdata_o(rdata), .ready_irq_o(irq));

  ////////////////////////////////////////////////////////////////
  function automatic logic [7:0] stat(input logic ee, input logic pe, input logic ra);
    return {1'b1, 1'b0, ee, pe, 3'b000, ra};
  endfunction : stat

  function automatic logic [31:0] xs(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    return s ^ (s << 5);
  endfunction : xs

  task automatic test_done();
    $display("checks %0d mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : test_done

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    check_count++;
    if (got !== exp)
    begin
      n_fail++;
      $display("ERROR %0t: got %h want %h", $time, got, exp);
    end
  endtask : chk

  task automatic rdc(input logic [11:0] a, input logic [7:0] m, input logic [7:0] e);
    logic [7:0] v;
    cpu.rd_b(a, v);
    chk(v & m, e);
  endtask : rdc

  task automatic wait_rdy();
    logic [7:0] v;
    for (int i = 0; i < 200; i++)
    begin
      cpu.rd_b(12'h803, v);
      if (v[ST_READY] === 1'b1)
        return;
    end
    n_fail++;
    $display("ERROR %0t: ready timeout", $time);
    test_done();
  endtask : wait_rdy

  task automatic wait_irq(output int k);
    for (k = 0; k < 200; k++)
    begin
      cpu.idle();
      if (irq === 1'b1)
        return;
    end
    n_fail++;
    $display("ERROR %0t: interrupt timeout", $time);
    test_done();
  endtask : wait_irq

  ////////////////////////////////////////////////////////////////
  initial
  begin
    nrst_i = 1'b0;
    n_fail = 0;
    check_count = 0;
    seed = 32'h0000_f4fb;
    repeat (8) @(posedge clk_i);
    nrst_i <= 1'b1;
    @(posedge clk_i);
    #1;
    rdc(12'h803, 8'hff, 8'h81);
    rdc(12'h801, 8'hff, 8'h00);
    cpu.wr_b(12'h807, 8'h5a);
    rdc(12'h807, 8'hff, 8'h00);
    cpu.wr_b(12'h800, 8'h09);
    $display("test reset done");
    seed = xs(seed);
    cpu.prog({4'h4, seed[7:0]}, seed[15:8] & 8'hfe);
    rdc(12'h803, 8'h80, 8'h00);
    rdc({4'h0, seed[23:16]}, 8'hff, 8'hff);
    rdc(12'h5f0, 8'hff, 8'h00);
    wait_irq(n);
    chk(8'(n + 4), 8'(PC));
    rdc(12'h803, 8'hb1, stat(0, 0, 1));
    rdc({4'h4, seed[7:0]}, 8'hff, seed[15:8] & 8'hfe);
    for (int i = 0; i < 4; i++)
    begin
      seed = xs(seed);
      pa[i] = 12'h100 + 12'(i * 64) + {6'h00, seed[5:0]};
      pd[i] = seed[15:8];
      cpu.prog(pa[i], pd[i] & 8'hfe);
      wait_rdy();
      rdc(12'h803, 8'h30, 8'h00);
    end
    for (int i = 0; i < 4; i++)
      rdc(pa[i], 8'hff, pd[i] & 8'hfe);
    cpu.cmd2(CMD_ERASE, 12'h140);
    wait_rdy();
    rdc(12'h803, 8'hb1, stat(0, 0, 1));
    for (int i = 0; i < 4; i++)
      rdc(pa[i], 8'hff, ERASED_BYTE);
    $display("test program erase done");
    cpu.wr_b(12'h800, 8'h01);
    cpu.cmd2(CMD_LOCK_PROG, 12'h200);
    wait_rdy();
    cpu.cmd2(CMD_LOCK_READ, 12'h200);
    wait_rdy();
    rdc(12'h803, 8'h02, 8'h00);
    cpu.prog(12'h210, 8'h12);
    cpu.idle();
    rdc(12'h803, 8'hf0, 8'h90);
    cpu.wr_b(12'h000, CMD_READ_ARRAY);
    rdc(12'h210, 8'hff, 8'hff);
    cpu.wr_b(12'h000, CMD_CLR_STATUS);
    rdc(12'h803, 8'h30, 8'h00);
    cpu.wr_b(12'h801, 8'h01);
    cpu.cmd2(CMD_LOCK_READ, 12'h200);
    wait_rdy();
    rdc(12'h803, 8'h02, 8'h00);
    rdc(12'h801, 8'h01, 8'h00);
    cpu.wr_b(12'h801, 8'h01);
    cpu.cmd2(CMD_ERASE, 12'h2c0);
    wait_rdy();
    rdc(12'h801, 8'h01, 8'h00);
    cpu.cmd2(CMD_LOCK_READ, 12'h200);
    wait_rdy();
    rdc(12'h803, 8'h02, 8'h02);
    $display("test lock done");
    for (int i = 0; i < 4; i++)
    begin
      seed = xs(seed);
      c = seed[7:0];
      if (c inside {8'hff, 8'h50, 8'h40, 8'h20, 8'h77, 8'h71, 8'h25, 8'hd0})
        c = 8'h33;
      cpu.wr_b({4'h3, seed[15:8]}, c);
      rdc(12'h803, 8'h30, 8'h30);
      cpu.wr_b(12'h801, 8'h01);
      cpu.wr_b(12'h000, c);
      rdc(12'h801, 8'h01, 8'h00);
      cpu.wr_b(12'h000, CMD_CLR_STATUS);
    end
    $display("test sequence error done");
    cpu.prog(12'h410, 8'h3c);
    wait_rdy();
    cpu.wr_b(12'h801, 8'h10);
    cpu.cmd2(CMD_ERASE, 12'h400);
    cpu.idle();
    rdc(12'h803, 8'hb0, 8'h80);
    cpu.wr_b(12'h000, CMD_READ_ARRAY);
    rdc(12'h410, 8'hff, 8'h3c);
    cpu.wr_b(12'h801, 8'h00);
    cpu.wr_b(12'h400, CMD_ERASE);
    cpu.wr_b(12'h400, CMD_READ_ARRAY);
    rdc(12'h803, 8'hb1, stat(0, 0, 1));
    rdc(12'h410, 8'hff, 8'h3c);
    cpu.cmd2(CMD_BLANK, 12'h400);
    wait_rdy();
    rdc(12'h803, 8'h30, 8'h20);
    cpu.wr_b(12'h000, CMD_CLR_STATUS);
    $display("test disable blank done");
    cpu.wr_b(12'h800, 8'h09);
    cpu.wr_b(12'h802, 8'h01);
    cpu.cmd2(CMD_ERASE, 12'h500);
    cpu.wr_b(12'h802, 8'h03);
    wait_irq(n);
    rdc(12'h803, 8'hc1, 8'hc1);
    cpu.wr_b(12'h802, 8'h01);
    cpu.idle();
    rdc(12'h803, 8'hc0, 8'h00);
    wait_rdy();
    rdc(12'h803, 8'hf0, 8'h80);
    cpu.wr_b(12'h801, 8'h01);
    cpu.wr_b(12'h800, 8'h05);
    rdc(12'h801, 8'h01, 8'h00);
    $display("test suspend reset done");
    test_done();
  end
endmodule : tb
